// ### hdl/track_formatter.sv
// Diskette track formatter: writes a formatted track and checks fields read back
`timescale 1ns/10ps
`include "track_fmt_defs.svh"
module track_formatter (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_index,
  input  wire logic       i_start,
  input  wire logic       i_mfm,
  input  wire logic       i_double_sided,
  input  wire logic       i_defective,
  input  wire logic       i_head,
  input  wire logic [6:0] i_cylinder,
  input  wire logic [1:0] i_len_code,
  input  wire logic [7:0] i_sector_count,
  input  wire logic       i_ctrl_field,
  input  wire logic [7:0] i_ctrl_flag,
  input  wire logic [7:0] i_wr_data,
  output logic            o_wr_ready,
  input  wire logic       i_byte_tick,
  output logic      [7:0] o_wr_byte,
  output logic            o_wr_valid,
  output logic            o_wr_mark,
  output logic            o_busy,
  output logic            o_param_err,
  input  wire logic [7:0] i_rd_byte,
  input  wire logic       i_rd_valid,
  input  wire logic       i_rd_mark,
  output logic            o_rd_id_ok,
  output logic            o_rd_id_err,
  output logic            o_rd_data_ok,
  output logic            o_rd_data_err,
  output logic            o_rd_defective,
  output logic            o_rd_ctrl,
  output logic      [7:0] o_rd_ctrl_flag,
  output logic      [7:0] o_rd_sector
);
  logic       rst_meta;
  logic       rst_n;
  logic       index_s;
  logic       index_d;
  logic       index_rise;

  // Reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  sync2_unit #(.WIDTH(1)) u_index_sync (
    .i_core_clk (i_core_clk),
    .rst_n      (rst_n),
    .i_async    (i_index),
    .o_sync     (index_s)
  );

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_d <= 1'b0;
    end else begin
      index_d <= index_s;
    end
  end
  assign index_rise = index_s & ~index_d;

  // ---------------- Write side ----------------
  track_fmt_pkg::fmt_state_t state;
  track_fmt_pkg::fmt_state_t next_state;
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic        in_data;
  logic        next_in_data;
  logic [7:0]  sector;
  logic [7:0]  next_sector;
  logic        armed;
  logic        fill_mode;
  logic [7:0]  next_byte;
  logic        next_mark;
  logic        crc_en;
  logic        crc_pre;
  logic [15:0] wcrc;
  wire         step = i_byte_tick & o_busy;
  wire  [10:0] body_len = `REC_BASE_LEN << i_len_code;
  wire  [10:0] sync_len = i_mfm ? `SYNC_MFM_LEN : `SYNC_FM_LEN;
  wire  [10:0] gap1_len = i_mfm ? `GAP1_MFM_LEN : `GAP1_FM_LEN;
  wire  [10:0] gap2_len = i_mfm ? `GAP2_MFM_LEN : `GAP2_FM_LEN;
  wire  [7:0]  fill_byte = i_mfm ? `FILL_MFM : `FILL_FM;
  wire  [7:0]  mark_byte = !in_data ? `ID_MARK :
                           (i_ctrl_field ? `CTRL_MARK : `DATA_MARK);
  logic [10:0] gap3_len;
  logic        len_ok;
  wire         track_ok = (i_cylinder <= `TRK_LAST) &&
                          (i_double_sided || !i_head);
  wire         alt_track = (i_cylinder >= `TRK_ALT_FIRST);
  wire  [7:0]  addr_byte = i_defective ? `DEFECT_BYTE :
                           (cnt == 11'd0) ? {1'b0, i_cylinder} :
                           (cnt == 11'd1) ? {7'h00, i_head} :
                           (cnt == 11'd2) ? sector : {6'h00, i_len_code};
  wire  [7:0]  body_byte = (i_ctrl_field && cnt == 11'd0) ? i_ctrl_flag : i_wr_data;
  wire         last_sector = (sector == i_sector_count);

  // Gap after sector by mode and length; unsupported pairs flagged
  always_comb begin
    gap3_len = `GAP3_FM_128;
    len_ok   = 1'b1;
    unique case ({i_mfm, i_len_code})
      3'b000: gap3_len = `GAP3_FM_128;
      3'b001: gap3_len = `GAP3_FM_256;
      3'b010: gap3_len = `GAP3_FM_512;
      3'b101: gap3_len = `GAP3_MFM_256;
      3'b110: gap3_len = `GAP3_MFM_512;
      3'b111: gap3_len = `GAP3_MFM_1024;
      default: len_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_in_data = in_data;
    next_sector  = sector;
    next_byte    = fill_byte;
    next_mark    = 1'b0;
    crc_en       = 1'b0;
    crc_pre      = 1'b0;
    o_wr_ready   = 1'b0;
    unique case (state)
      track_fmt_pkg::ST_IDLE: begin
        next_byte = fill_byte;
      end
      track_fmt_pkg::ST_GAP1: begin
        next_byte = fill_byte;
        if (cnt == gap1_len - 11'd1) begin
          next_state = track_fmt_pkg::ST_SYNC;
          next_cnt   = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      track_fmt_pkg::ST_SYNC: begin
        next_byte = `SYNC_BYTE;
        crc_pre   = 1'b1;
        if (cnt == sync_len - 11'd1) begin
          next_state = i_mfm ? track_fmt_pkg::ST_PFX : track_fmt_pkg::ST_MARK;
          next_cnt   = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      track_fmt_pkg::ST_PFX: begin
        next_byte = `MARK_PREFIX;
        next_mark = 1'b1;
        crc_en    = 1'b1;
        if (cnt == `MARK_PREFIX_LEN - 11'd1) begin
          next_state = track_fmt_pkg::ST_MARK;
          next_cnt   = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      track_fmt_pkg::ST_MARK: begin
        next_byte  = mark_byte;
        crc_en     = 1'b1;
        next_cnt   = 11'd0;
        next_state = in_data ? track_fmt_pkg::ST_BODY : track_fmt_pkg::ST_ADDR;
      end
      track_fmt_pkg::ST_ADDR: begin
        next_byte = addr_byte;
        crc_en    = 1'b1;
        if (cnt == 11'd3) begin
          next_state = track_fmt_pkg::ST_CRC;
          next_cnt   = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      track_fmt_pkg::ST_BODY: begin
        next_byte  = body_byte;
        o_wr_ready = i_byte_tick;
        crc_en     = 1'b1;
        if (cnt == body_len - 11'd1) begin
          next_state = track_fmt_pkg::ST_CRC;
          next_cnt   = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      track_fmt_pkg::ST_CRC: begin
        next_byte = (cnt == 11'd0) ? wcrc[15:8] : wcrc[7:0];
        if (cnt == 11'd1) begin
          next_cnt   = 11'd0;
          next_state = in_data ? track_fmt_pkg::ST_GAP3 : track_fmt_pkg::ST_GAP2;
        end else begin
          next_cnt = 11'd1;
        end
      end
      track_fmt_pkg::ST_GAP2: begin
        next_byte = fill_byte;
        if (cnt == gap2_len - 11'd1) begin
          next_state   = track_fmt_pkg::ST_SYNC;
          next_in_data = 1'b1;
          next_cnt     = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      track_fmt_pkg::ST_GAP3: begin
        next_byte = fill_byte;
        if (last_sector) begin
          next_state = track_fmt_pkg::ST_IDLE;
        end else if (cnt == gap3_len - 11'd1) begin
          next_state   = track_fmt_pkg::ST_SYNC;
          next_in_data = 1'b0;
          next_sector  = sector + 8'h01;
          next_cnt     = 11'd0;
        end else begin
          next_cnt = cnt + 11'd1;
        end
      end
      default: next_state = track_fmt_pkg::ST_IDLE;
    endcase
  end

  crc16_unit u_wcrc (
    .i_core_clk (i_core_clk),
    .rst_n      (rst_n),
    .i_preset   (step & crc_pre),
    .i_en       (step & crc_en),
    .i_byte     (next_byte),
    .o_crc      (wcrc)
  );

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= track_fmt_pkg::ST_IDLE;
      cnt         <= 11'd0;
      in_data     <= 1'b0;
      sector      <= `SECTOR_FIRST;
      armed       <= 1'b0;
      fill_mode   <= 1'b0;
      o_busy      <= 1'b0;
      o_param_err <= 1'b0;
    end else if (index_rise && armed) begin
      state     <= track_fmt_pkg::ST_GAP1;
      cnt       <= 11'd0;
      in_data   <= 1'b0;
      sector    <= `SECTOR_FIRST;
      armed     <= 1'b0;
      fill_mode <= 1'b0;
      o_busy    <= 1'b1;
    end else if (index_rise && fill_mode) begin
      fill_mode <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      if (i_start && !o_busy && !armed) begin
        armed       <= track_ok && len_ok && (i_sector_count != 8'h00);
        o_param_err <= !(track_ok && len_ok && (i_sector_count != 8'h00)) ||
                       (alt_track && !i_defective && 1'b0);
      end
      if (step) begin
        state   <= next_state;
        cnt     <= next_cnt;
        in_data <= next_in_data;
        sector  <= next_sector;
        if (next_state == track_fmt_pkg::ST_IDLE) begin
          fill_mode <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wr_byte  <= 8'h00;
      o_wr_valid <= 1'b0;
      o_wr_mark  <= 1'b0;
    end else begin
      o_wr_valid <= step;
      if (step) begin
        o_wr_byte <= next_byte;
        o_wr_mark <= next_mark;
      end
    end
  end

  // ---------------- Read side ----------------
  logic [2:0]  rd_phase;
  logic [10:0] rd_cnt;
  logic        rd_is_data;
  logic [1:0]  rd_len;
  logic [7:0]  rd_addr0;
  logic        rd_all_ff;
  logic [15:0] rcrc;
  logic        rcrc_hold;
  logic        next_rcrc_zero;
  logic [15:0] racc;
  // In MFM a mark byte counts only straight after a marked prefix byte
  wire         rd_mark_byte = !i_mfm || rcrc_hold;
  wire         rd_id_mark = (i_rd_byte == `ID_MARK);
  wire         rd_dt_mark = (i_rd_byte == `DATA_MARK) || (i_rd_byte == `CTRL_MARK);
  wire         rd_start = i_rd_valid && rd_phase == 3'd0 && (rd_id_mark || rd_dt_mark);
  wire  [10:0] rd_body = `REC_BASE_LEN << rd_len;
  wire         rd_pre = i_rd_valid && i_rd_mark && rd_phase == 3'd0 &&
                        i_rd_byte == `MARK_PREFIX;

  crc16_unit u_rcrc (
    .i_core_clk (i_core_clk),
    .rst_n      (rst_n),
    .i_preset   (i_rd_valid && rd_phase == 3'd0 && !rd_start && !rd_pre),
    .i_en       (i_rd_valid && (rd_phase != 3'd0 || rd_start || rd_pre)),
    .i_byte     (i_rd_byte),
    .o_crc      (rcrc)
  );

  // Remembers that the last read byte was a marked prefix byte
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcrc_hold <= 1'b0;
    end else if (i_rd_valid) begin
      rcrc_hold <= rd_pre;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_phase <= 3'd0;
      rd_cnt   <= 11'd0;
      rd_is_data <= 1'b0;
      rd_len   <= 2'd0;
      rd_addr0 <= 8'h00;
      rd_all_ff <= 1'b0;
      o_rd_id_ok <= 1'b0;
      o_rd_id_err <= 1'b0;
      o_rd_data_ok <= 1'b0;
      o_rd_data_err <= 1'b0;
      o_rd_defective <= 1'b0;
      o_rd_ctrl <= 1'b0;
      o_rd_ctrl_flag <= 8'h00;
      o_rd_sector <= 8'h00;
    end else begin
      o_rd_id_ok    <= 1'b0;
      o_rd_id_err   <= 1'b0;
      o_rd_data_ok  <= 1'b0;
      o_rd_data_err <= 1'b0;
      if (index_rise) begin
        rd_phase <= 3'd0;
      end else if (i_rd_valid) begin
        unique case (rd_phase)
          3'd0: if (rd_start && (rd_mark_byte || !i_mfm)) begin
            rd_is_data <= rd_dt_mark;
            o_rd_ctrl  <= (i_rd_byte == `CTRL_MARK);
            rd_phase   <= rd_dt_mark ? 3'd2 : 3'd1;
            rd_cnt     <= 11'd0;
            rd_all_ff  <= 1'b1;
          end
          3'd1: begin
            rd_all_ff <= rd_all_ff && (i_rd_byte == `DEFECT_BYTE);
            if (rd_cnt == 11'd2) o_rd_sector <= i_rd_byte;
            if (rd_cnt == 11'd3) begin
              // A defective ID carries no length: the track's own code stands in
              rd_len   <= (rd_all_ff && i_rd_byte == `DEFECT_BYTE) ? i_len_code :
                          i_rd_byte[1:0];
              rd_phase <= 3'd3;
              rd_cnt   <= 11'd0;
            end else begin
              rd_cnt <= rd_cnt + 11'd1;
            end
          end
          3'd2: begin
            if (rd_cnt == 11'd0) o_rd_ctrl_flag <= i_rd_byte;
            if (rd_cnt == rd_body - 11'd1) begin
              rd_phase <= 3'd3;
              rd_cnt   <= 11'd0;
            end else begin
              rd_cnt <= rd_cnt + 11'd1;
            end
          end
          3'd3: begin
            if (rd_cnt == 11'd1) begin
              rd_phase <= 3'd0;
              o_rd_id_ok    <= !rd_is_data && next_rcrc_zero;
              o_rd_id_err   <= !rd_is_data && !next_rcrc_zero;
              o_rd_data_ok  <= rd_is_data && next_rcrc_zero;
              o_rd_data_err <= rd_is_data && !next_rcrc_zero;
              if (!rd_is_data) o_rd_defective <= rd_all_ff;
            end else begin
              rd_cnt <= 11'd1;
            end
          end
          default: rd_phase <= 3'd0;
        endcase
      end
    end
  end

  // Residue check: running CRC over the received check bytes ends at zero
  always_comb begin
    racc = rcrc;
    for (int b = 7; b >= 0; b--) begin
      racc = (racc[15] ^ i_rd_byte[b]) ? ({racc[14:0], 1'b0} ^ `CRC_POLY) :
                                         {racc[14:0], 1'b0};
    end
    next_rcrc_zero = (racc == 16'h0000);
  end
endmodule // track_formatter

// ### hdl/track_fmt_defs.svh
// Constants for the diskette track formatter: field lengths, fill bytes, marks, flags
`ifndef TRACK_FMT_DEFS_SVH
`define TRACK_FMT_DEFS_SVH
`define TRK_COUNT       7'd77
`define TRK_LAST        7'd76
`define TRK_LABEL       7'd0
`define TRK_ALT_FIRST   7'd75
`define TRK_ALT_LAST    7'd76
`define SECTOR_FIRST    8'h01
`define GAP1_FM_LEN     11'd73
`define GAP1_MFM_LEN    11'd146
`define SYNC_FM_LEN     11'd6
`define SYNC_MFM_LEN    11'd12
`define GAP2_FM_LEN     11'd11
`define GAP2_MFM_LEN    11'd22
`define GAP3_FM_128     11'd27
`define GAP3_FM_256     11'd42
`define GAP3_FM_512     11'd58
`define GAP3_MFM_256    11'd54
`define GAP3_MFM_512    11'd84
`define GAP3_MFM_1024   11'd116
`define REC_BASE_LEN    11'd128
`define FILL_FM         8'hff
`define FILL_MFM        8'h4e
`define SYNC_BYTE       8'h00
`define MARK_PREFIX     8'ha1
`define MARK_PREFIX_LEN 11'd3
`define ID_MARK         8'hfe
`define DATA_MARK       8'hfb
`define CTRL_MARK       8'hf8
`define DEFECT_BYTE     8'hff
`define FLAG_DELETED    8'hc4
`define FLAG_NEXT_PHYS  8'hc6
`define FLAG_RELOCATED  8'h4b
`define CRC_PRESET      16'hffff
`define CRC_POLY        16'h1021
`endif

// ### hdl/track_fmt_pkg.sv
// Types shared by the diskette track formatter
package track_fmt_pkg;
  typedef enum logic [9:0] {
    ST_IDLE  = 10'b0000000001,
    ST_GAP1  = 10'b0000000010,
    ST_SYNC  = 10'b0000000100,
    ST_PFX   = 10'b0000001000,
    ST_MARK  = 10'b0000010000,
    ST_ADDR  = 10'b0000100000,
    ST_CRC   = 10'b0001000000,
    ST_GAP2  = 10'b0010000000,
    ST_BODY  = 10'b0100000000,
    ST_GAP3  = 10'b1000000000
  } fmt_state_t;
endpackage

// ### hdl/crc16_unit.sv
// Byte-wide CRC-16 (x^16+x^12+x^5+1) register with preset
`timescale 1ns/10ps
`include "track_fmt_defs.svh"
module crc16_unit (
  input  wire logic        i_core_clk,
  input  wire logic        rst_n,
  input  wire logic        i_preset,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_byte,
  output logic      [15:0] o_crc
);
  logic [15:0] next_crc;
  logic [15:0] acc;

  always_comb begin
    acc = o_crc;
    for (int b = 7; b >= 0; b--) begin
      if (acc[15] ^ i_byte[b]) begin
        acc = {acc[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        acc = {acc[14:0], 1'b0};
      end
    end
    next_crc = acc;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_crc <= `CRC_PRESET;
    end else if (i_preset) begin
      o_crc <= `CRC_PRESET;
    end else if (i_en) begin
      o_crc <= next_crc;
    end
  end
endmodule // crc16_unit

// ### hdl/sync2_unit.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module sync2_unit #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // sync2_unit

// ### test/track_fmt_chk.sv
// Concurrent checks on the track formatter ports
`timescale 1ns/10ps
module track_fmt_chk (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_index,
  input  wire logic       i_mfm,
  input  wire logic       i_byte_tick,
  input  wire logic       i_rd_valid,
  input  wire logic       o_wr_ready,
  input  wire logic [7:0] o_wr_byte,
  input  wire logic       o_wr_valid,
  input  wire logic       o_wr_mark,
  input  wire logic       o_busy,
  input  wire logic       o_param_err,
  input  wire logic       o_rd_id_ok,
  input  wire logic       o_rd_id_err,
  input  wire logic       o_rd_data_ok,
  input  wire logic       o_rd_data_err
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_valid_tick; o_wr_valid |-> $past(i_byte_tick); endproperty
  a_valid_tick: assert property (p_valid_tick)
    else $error("write strobe without a byte time");
  property p_byte_holds; !$past(i_byte_tick) |-> $stable(o_wr_byte); endproperty
  a_byte_holds: assert property (p_byte_holds)
    else $error("write byte changed between byte times");
  property p_mark_a1; o_wr_valid && o_wr_mark |-> o_wr_byte == 8'ha1; endproperty
  a_mark_a1: assert property (p_mark_a1)
    else $error("missing clock flag on a byte other than a1");
  property p_mark_mfm; o_wr_valid && o_wr_mark |-> i_mfm; endproperty
  a_mark_mfm: assert property (p_mark_mfm)
    else $error("missing clock flag in single density");
  property p_ready_tick; o_wr_ready |-> i_byte_tick && o_busy; endproperty
  a_ready_tick: assert property (p_ready_tick)
    else $error("body byte taken outside a byte time");
  property p_busy_index; $rose(o_busy) |-> $past(i_index, 3); endproperty
  a_busy_index: assert property (p_busy_index)
    else $error("track started away from the index");
  property p_start_clean; $rose(o_busy) |-> !o_param_err; endproperty
  a_start_clean: assert property (p_start_clean)
    else $error("track started with a parameter error");
  property p_rd_after_byte;
    (o_rd_id_ok || o_rd_id_err || o_rd_data_ok || o_rd_data_err) |-> $past(i_rd_valid);
  endproperty
  a_rd_after_byte: assert property (p_rd_after_byte)
    else $error("read verdict without a read byte");
  property p_id_excl; o_rd_id_ok |-> !o_rd_id_err ##1 !(o_rd_id_ok || o_rd_id_err); endproperty
  a_id_excl: assert property (p_id_excl)
    else $error("id verdict not a single clean pulse");
  property p_data_excl;
    o_rd_data_ok |-> !o_rd_data_err ##1 !(o_rd_data_ok || o_rd_data_err);
  endproperty
  a_data_excl: assert property (p_data_excl)
    else $error("data verdict not a single clean pulse");
endmodule // track_fmt_chk

bind track_formatter track_fmt_chk u_chk (.i_core_clk, .i_rst_n, .i_index, .i_mfm,
  .i_byte_tick, .i_rd_valid, .o_wr_ready, .o_wr_byte, .o_wr_valid, .o_wr_mark, .o_busy,
  .o_param_err, .o_rd_id_ok, .o_rd_id_err, .o_rd_data_ok, .o_rd_data_err);

// ### test/drive_model.sv
// Drive model: byte-time pacing and index pulse of a spinning diskette
`timescale 1ns/10ps
module drive_model #(
  parameter int TICK_DIV  = 4,
  parameter int REV_BYTES = 700
) (
  input  wire logic i_core_clk,
  input  wire logic i_spin,
  output logic      o_byte_tick,
  output logic      o_index
);
  int div_cnt = 0;
  int byte_cnt = 0;
  initial begin
    o_byte_tick = 1'b0;
    o_index = 1'b0;
  end
  // Index hole wide enough to pass the pin synchroniser
  always @(negedge i_core_clk) begin
    o_byte_tick <= i_spin && (div_cnt == TICK_DIV - 1);
    o_index <= i_spin && (byte_cnt < 2);
    div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
    if (div_cnt == TICK_DIV - 1)
      byte_cnt <= (byte_cnt == REV_BYTES - 1) ? 0 : byte_cnt + 1;
  end
endmodule // drive_model

// ### test/tb.sv
// Testbench for the diskette track formatter
`timescale 1ns/10ps
module tb;
  logic        i_core_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, i_mfm = 1'b0, spin = 1'b0;
  logic        i_double_sided = 1'b0, i_defective = 1'b0, i_head = 1'b0, i_ctrl_field = 1'b0;
  logic        i_rd_valid = 1'b0, i_rd_mark = 1'b0, i_index, i_byte_tick;
  logic [6:0]  i_cylinder = 7'h00;
  logic [1:0]  i_len_code = 2'h0;
  logic [7:0]  i_sector_count = 8'h01, i_ctrl_flag = 8'h00, i_wr_data = 8'h03, i_rd_byte = 8'h00;
  logic        o_wr_ready, o_wr_valid, o_wr_mark, o_busy, o_param_err, o_rd_id_ok, o_rd_id_err;
  logic        o_rd_data_ok, o_rd_data_err, o_rd_defective, o_rd_ctrl;
  logic [7:0]  o_wr_byte, o_rd_ctrl_flag, o_rd_sector;
  logic [9:0]  exp_q[$];
  logic [8:0]  cap_q[$];
  logic [15:0] crc;
  int error_cnt = 0, cmp_count = 0, wr_idx = 0, didx = 0;
  int n_ido = 0, n_ide = 0, n_do = 0, n_de = 0;

  drive_model #(.TICK_DIV(4), .REV_BYTES(700)) drive (.i_core_clk, .i_spin(spin),
    .o_byte_tick(i_byte_tick), .o_index(i_index));
  track_formatter uut (.i_core_clk, .i_rst_n, .i_index, .i_start, .i_mfm, .i_double_sided,
    .i_defective, .i_head, .i_cylinder, .i_len_code, .i_sector_count, .i_ctrl_field,
    .i_ctrl_flag, .i_wr_data, .o_wr_ready, .i_byte_tick, .o_wr_byte, .o_wr_valid, .o_wr_mark,
    .o_busy, .o_param_err, .i_rd_byte, .i_rd_valid, .i_rd_mark, .o_rd_id_ok, .o_rd_id_err,
    .o_rd_data_ok, .o_rd_data_err, .o_rd_defective, .o_rd_ctrl, .o_rd_ctrl_flag, .o_rd_sector);

  initial forever #4 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk) begin
    if (o_wr_valid === 1'b1) cap_q.push_back({o_wr_mark, o_wr_byte});
    if (o_wr_ready === 1'b1) wr_idx <= wr_idx + 1;
    n_ido <= n_ido + int'(o_rd_id_ok === 1'b1);
    n_ide <= n_ide + int'(o_rd_id_err === 1'b1);
    n_do <= n_do + int'(o_rd_data_ok === 1'b1);
    n_de <= n_de + int'(o_rd_data_err === 1'b1);
  end
  always @(negedge i_core_clk) i_wr_data <= 8'(wr_idx * 7 + 3);

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_busy(input logic lvl);
    for (int k = 0; k < 4000 && o_busy !== lvl; k++) @(negedge i_core_clk);
    if (o_busy !== lvl) begin
      check("busy wait", 16'(lvl), 16'(o_busy));
      complete_run();
    end
  endtask

  task automatic pulse_start();
    @(negedge i_core_clk);
    i_start = 1'b1;
    @(negedge i_core_clk);
    i_start = 1'b0;
  endtask

  task automatic put(input int n, input logic [7:0] b, input logic m, input logic dc);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back({dc, m, b});
      for (int j = 7; j >= 0; j--)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[j]) ? 16'h1021 : 16'h0000);
    end
  endtask

  task automatic build(input logic mfm, input logic [1:0] len, input int cnt,
                       input logic [6:0] cyl, input logic hd, input logic def,
                       input logic ctl, input logic [7:0] flag);
    logic [7:0]  fill;
    logic [15:0] c;
    int          nb;
    fill = mfm ? 8'h4e : 8'hff;
    nb = 128 << len;
    exp_q = {};
    didx = 0;
    put(mfm ? 146 : 73, fill, 1'b0, 1'b0);
    for (int s = 1; s <= cnt; s++) begin
      for (int f = 0; f < 2; f++) begin
        put(mfm ? 12 : 6, 8'h00, 1'b0, 1'b0);
        crc = 16'hffff;
        if (mfm) put(3, 8'ha1, 1'b1, 1'b0);
        if (f == 0) begin
          put(1, 8'hfe, 1'b0, 1'b0);
          put(1, def ? 8'hff : {1'b0, cyl}, 1'b0, 1'b0);
          put(1, def ? 8'hff : {7'h00, hd}, 1'b0, 1'b0);
          put(1, def ? 8'hff : 8'(s), 1'b0, 1'b0);
          put(1, def ? 8'hff : {6'h00, len}, 1'b0, 1'b0);
        end else begin
          put(1, ctl ? 8'hf8 : 8'hfb, 1'b0, 1'b0);
          if (ctl) put(1, flag, 1'b0, 1'b0);
          for (int k = int'(ctl); k < nb; k++) begin
            put(1, 8'(didx * 7 + 3), 1'b0, ctl);
            didx++;
          end
        end
        c = crc;
        put(1, c[15:8], 1'b0, ctl && f == 1);
        put(1, c[7:0], 1'b0, ctl && f == 1);
        if (f == 0) put(mfm ? 22 : 11, fill, 1'b0, 1'b0);
      end
      if (s < cnt) put(mfm ? (len == 1 ? 54 : len == 2 ? 84 : 116)
                           : (len == 0 ? 27 : len == 1 ? 42 : 58), fill, 1'b0, 1'b0);
    end
  endtask

  // Feeds a captured track back, with one byte optionally spoilt
  task automatic replay(input int bad);
    n_ido = 0; n_ide = 0; n_do = 0; n_de = 0;
    foreach (cap_q[i]) begin
      @(negedge i_core_clk);
      i_rd_byte = cap_q[i][7:0] ^ ((i == bad) ? 8'h10 : 8'h00);
      i_rd_mark = cap_q[i][8];
      i_rd_valid = 1'b1;
      @(negedge i_core_clk);
      i_rd_byte = ~i_rd_byte;
      i_rd_mark = 1'b0;
      i_rd_valid = 1'b0;
    end
    repeat (3) @(negedge i_core_clk);
  endtask

  task automatic run_track(input logic mfm, input logic [1:0] len, input int cnt,
                           input logic [6:0] cyl, input logic hd, input logic def,
                           input logic ctl, input logic [7:0] flag);
    @(negedge i_core_clk);
    i_mfm = mfm; i_len_code = len; i_sector_count = 8'(cnt); i_cylinder = cyl;
    i_head = hd; i_defective = def; i_ctrl_field = ctl; i_ctrl_flag = flag;
    i_double_sided = 1'b1;
    build(mfm, len, cnt, cyl, hd, def, ctl, flag);
    cap_q = {};
    wr_idx = 0;
    pulse_start();
    wait_busy(1'b1);
    check("param_err", 16'h0, 16'(o_param_err));
    wait_busy(1'b0);
    check("length", 16'h1, 16'(exp_q.size() <= cap_q.size()));
    for (int i = 0; i < cap_q.size(); i++)
      if (i >= exp_q.size())
        check($sformatf("fill %0d", i), {7'h00, 1'b0, mfm ? 8'h4e : 8'hff}, 16'(cap_q[i]));
      else if (exp_q[i][9] === 1'b0)
        check($sformatf("byte %0d", i), 16'(exp_q[i][8:0]), 16'(cap_q[i]));
    replay(-1);
    check("id_ok", 16'(cnt), 16'(n_ido));
    check("data_ok", 16'(cnt), 16'(n_do));
    check("sector", def ? 16'hff : 16'(cnt), 16'(o_rd_sector));
    check("defective", 16'(def), 16'(o_rd_defective));
    check("ctrl", 16'(ctl), 16'(o_rd_ctrl));
    if (ctl) check("flag", 16'(flag), 16'(o_rd_ctrl_flag));
  endtask

  task automatic reset_values();
    check("busy", 16'h0, 16'(o_busy));
    check("wr_valid", 16'h0, 16'(o_wr_valid));
    check("wr_byte", 16'h0, 16'(o_wr_byte));
    check("param_err", 16'h0, 16'(o_param_err));
  endtask

  task automatic bad_params();
    logic seen;
    seen = 1'b0;
    for (int c = 0; c < 4; c++) begin
      @(negedge i_core_clk);
      i_mfm = (c == 1);
      i_len_code = (c == 0) ? 2'h3 : 2'h0;
      i_cylinder = (c == 2) ? 7'd77 : 7'd3;
      i_head = (c == 3);
      pulse_start();
      repeat (4) @(negedge i_core_clk);
      check($sformatf("param_err %0d", c), 16'h1, 16'(o_param_err));
    end
    for (int k = 0; k < 3000; k++) begin
      @(negedge i_core_clk);
      if (o_busy !== 1'b0) seen = 1'b1;
    end
    check("busy_refused", 16'h0, 16'(seen));
  endtask

  task automatic mfm_track();
    run_track(1'b1, 2'h1, 1, 7'd76, 1'b1, 1'b0, 1'b0, 8'h00);
    replay(206);
    check("data_err", 16'h1, 16'(n_de));
    check("data_ok", 16'h0, 16'(n_do));
    replay(162);
    check("id_err", 16'h1, 16'(n_ide));
    check("id_ok", 16'h0, 16'(n_ido));
  endtask

  task automatic ctrl_tracks();
    logic [7:0] flags [3];
    flags = '{8'hc4, 8'hc6, 8'h4b};
    for (int k = 0; k < 3; k++)
      run_track(1'b0, (k == 1) ? 2'h2 : 2'h1, 1, 7'd75, 1'b0, k == 0, 1'b1, flags[k]);
  endtask

  initial begin
    repeat (12) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    spin = 1'b1;
    repeat (5) @(negedge i_core_clk);
    reset_values();
    bad_params();
    run_track(1'b0, 2'h0, 2, 7'd5, 1'b0, 1'b0, 1'b0, 8'h00);
    mfm_track();
    ctrl_tracks();
    complete_run();
  end
endmodule // tb
